// *** blpc_core.sv ***
// What this block does
// - Hybrid: wrap once through the aligned group, then linear from next group.
// - Legacy wrap: step to group end, wrap, stop before start word repeats.
// - Linear: word address increments by one with no wrap until chip select ends.
// - Array access and register read wait latency from the configured field.
// - Latency after reset is seven clocks.
// - Pending refresh at start: strobe high in command phase, latency doubled.
// - Register write: no latency, data captured right after command phase.
// - Refresh may run during register write capture without disturbing it.
// - Fixed latency: strobe always high in command phase, two latency periods.
// - Fixed latency is on after power-on and hardware reset.
// - Three-bit drive strength field, reset value zero.
// - Clearing power-down bit enters lowest power state; refresh stops.
// - Chip select low then high, or any reset, wakes the device.
// - In lowest power state only chip select and reset pin are watched.
// - Power-down bit returns to one after waking.
// - Latency codes E,F,0,1,2 give 3 to 7 clocks; others reserved.
// - Burst length codes 128, 64, 16, 32 bytes; reset code 11.
// - Hybrid bit: 0 hybrid, 1 legacy, only for wrapped command bursts.
module blpc_core #(
  parameter int AW = blpc_pkg::ADDR_W,
  parameter int FD = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic ck,
  input wire logic resetN,
  input wire logic [7:0] dqIn,
  output logic [7:0] dqOut,
  output logic dqOe,
  input wire logic rwdsIn,
  output logic rwdsOut,
  output logic rwdsOe,
  output logic memValid,
  input wire logic memReady,
  output logic memWe,
  output logic [1:0] memMask,
  output logic [AW-1:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic [15:0] memRdata,
  output logic [2:0] driveStrength,
  output logic inPowerDown,
  output logic overrun
);
  localparam int FW = 3 + AW + 16;
  localparam int RCW = $clog2(blpc_pkg::REFRESH_CYC + 1);
  localparam int PCW = $clog2(blpc_pkg::PD_ENTRY_CYC + 1);
  localparam logic [RCW-1:0] REF_LOAD = RCW'(blpc_pkg::REFRESH_CYC - 1);
  localparam logic [4:0] BUSY_LOAD = 5'(blpc_pkg::REFRESH_BUSY_CYC);
  localparam logic [PCW-1:0] PD_LOAD = PCW'(blpc_pkg::PD_ENTRY_CYC - 1);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] latClocks(input logic [3:0] code);
    case (code)
      blpc_pkg::LAT_C3: latClocks = 4'h3;
      blpc_pkg::LAT_C4: latClocks = 4'h4;
      blpc_pkg::LAT_C5: latClocks = 4'h5;
      blpc_pkg::LAT_C6: latClocks = 4'h6;
      default: latClocks = 4'h7;
    endcase
  endfunction : latClocks

  function automatic logic [AW-1:0] grpMask(input logic [1:0] code);
    case (code)
      blpc_pkg::BL_128: grpMask = AW'(16'h003F);
      blpc_pkg::BL_64: grpMask = AW'(16'h001F);
      blpc_pkg::BL_16: grpMask = AW'(16'h0007);
      default: grpMask = AW'(16'h000F);
    endcase
  endfunction : grpMask

  function automatic logic [AW-1:0] wrapNext(input logic [AW-1:0] a, input logic [AW-1:0] m);
    wrapNext = (a & ~m) | ((a + AW'(1)) & m);
  endfunction : wrapNext

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [11:0] pinS1_r, pinS2_r;
  logic ckPrev_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinS1_r <= 12'hC00;
      pinS2_r <= 12'hC00;
      ckPrev_r <= 1'b0;
    end else begin
      pinS1_r <= {resetN, csN, ck, rwdsIn, dqIn};
      pinS2_r <= pinS1_r;
      ckPrev_r <= pinS2_r[9];
    end
  end
  logic hwRst, csS, ckS, rwdsS, edgeS;
  logic [7:0] dqS;
  assign hwRst = ~pinS2_r[11];
  assign csS = pinS2_r[10];
  assign ckS = pinS2_r[9];
  assign rwdsS = pinS2_r[8];
  assign dqS = pinS2_r[7:0];
  // Both clock edges carry a byte
  assign edgeS = ckS ^ ckPrev_r;

  // ----------------------------------------------------------------
  // Shared state and decode
  // ----------------------------------------------------------------
  blpc_pkg::blpc_state_type state_r;
  blpc_pkg::blpc_seq_type seq_r;
  logic [15:0] cfg_r;
  logic [47:0] ca_r, caNext;
  logic [2:0] byteCnt_r;
  logic [5:0] latCnt_r, latEdges;
  logic dbl_r, isRead_r, isReg_r, hiSel_r, refPend_r, csLow_r;
  logic [AW-1:0] addr_r, start_r, nextAddr, mask, wrapN, startAddr;
  logic wrapDone_r, seqStop_r, wrapDoneNxt, seqStopNxt;
  logic pushValid_r, fifoInReady;
  logic [FW-1:0] pushData_r, fifoOut;
  logic caLast, regWr, latDone, wordDone, wordAdv, wake;
  logic [PCW-1:0] pdCnt_r;
  assign caNext = {ca_r[39:0], dqS};
  assign caLast = (state_r == blpc_pkg::ST_CA) && edgeS && (byteCnt_r == 3'h5);
  assign regWr = !caNext[blpc_pkg::CA_RW] && caNext[blpc_pkg::CA_AS];
  assign latDone = (state_r == blpc_pkg::ST_LAT) && edgeS && (latCnt_r == 6'h01);
  assign wordDone = (state_r == blpc_pkg::ST_DATA) && edgeS && !hiSel_r;
  assign wordAdv = wordDone && (!pushValid_r || fifoInReady) && !seqStop_r;
  assign wake = (state_r == blpc_pkg::ST_PDOWN) && csS && csLow_r;
  assign startAddr = {caNext[blpc_pkg::CA_ALO +: AW-3], caNext[2:0]};
  assign mask = grpMask(cfg_r[blpc_pkg::BL_LO +: 2]);
  assign wrapN = wrapNext(addr_r, mask);
  // Fixed mode or a pending refresh doubles the wait
  assign latEdges = dbl_r ? {latClocks(cfg_r[blpc_pkg::LAT_LO +: 4]), 2'b00}
                          : {1'b0, latClocks(cfg_r[blpc_pkg::LAT_LO +: 4]), 1'b0};

  // ----------------------------------------------------------------
  // Transaction flow
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= blpc_pkg::ST_IDLE;
    end else if (hwRst) begin
      state_r <= blpc_pkg::ST_IDLE;
    end else begin
      case (state_r)
        blpc_pkg::ST_IDLE: if (!csS) state_r <= blpc_pkg::ST_CA;
        blpc_pkg::ST_CA: begin
          if (csS) state_r <= blpc_pkg::ST_IDLE;
          else if (caLast) state_r <= regWr ? blpc_pkg::ST_REGW : blpc_pkg::ST_LAT;
        end
        blpc_pkg::ST_LAT: begin
          if (csS) state_r <= blpc_pkg::ST_IDLE;
          else if (latDone) state_r <= blpc_pkg::ST_DATA;
        end
        blpc_pkg::ST_DATA: if (csS) state_r <= blpc_pkg::ST_IDLE;
        blpc_pkg::ST_REGW: begin
          if (csS) state_r <= cfg_r[blpc_pkg::PD_BIT] ? blpc_pkg::ST_IDLE
                                                     : blpc_pkg::ST_ENTRY;
        end
        blpc_pkg::ST_ENTRY: if (pdCnt_r == '0) state_r <= blpc_pkg::ST_PDOWN;
        blpc_pkg::ST_PDOWN: if (wake) state_r <= blpc_pkg::ST_IDLE;
        default: state_r <= blpc_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command capture and latency count
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ca_r <= '0;
      byteCnt_r <= 3'h0;
      latCnt_r <= 6'h00;
      dbl_r <= 1'b0;
    end else if (state_r == blpc_pkg::ST_IDLE) begin
      byteCnt_r <= 3'h0;
      dbl_r <= cfg_r[blpc_pkg::FIX_BIT] || refPend_r;
    end else if (edgeS) begin
      if (state_r == blpc_pkg::ST_CA) ca_r <= caNext;
      if (caLast) byteCnt_r <= 3'h0;
      else if (byteCnt_r != 3'h7) byteCnt_r <= byteCnt_r + 3'h1;
      if (caLast) latCnt_r <= latEdges;
      else if (state_r == blpc_pkg::ST_LAT) latCnt_r <= latCnt_r - 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Burst address sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nextAddr = addr_r + AW'(1);
    wrapDoneNxt = wrapDone_r;
    seqStopNxt = seqStop_r;
    case (seq_r)
      blpc_pkg::SEQ_WRAP: begin
        nextAddr = wrapN;
        seqStopNxt = (wrapN == start_r);
      end
      blpc_pkg::SEQ_HYB: begin
        if (!wrapDone_r && (wrapN == start_r)) begin
          nextAddr = (start_r & ~mask) + mask + AW'(1);
          wrapDoneNxt = 1'b1;
        end else if (!wrapDone_r) begin
          nextAddr = wrapN;
        end
      end
      default: nextAddr = addr_r + AW'(1);
    endcase
  end

  logic [7:0] hiByte_r;
  logic maskHi_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r <= '0;
      start_r <= '0;
      seq_r <= blpc_pkg::SEQ_LIN;
      isRead_r <= 1'b0;
      isReg_r <= 1'b0;
      wrapDone_r <= 1'b0;
      seqStop_r <= 1'b0;
      hiSel_r <= 1'b0;
      hiByte_r <= 8'h00;
      maskHi_r <= 1'b0;
    end else if (caLast) begin
      addr_r <= startAddr;
      start_r <= startAddr;
      isRead_r <= caNext[blpc_pkg::CA_RW];
      isReg_r <= caNext[blpc_pkg::CA_AS];
      if (caNext[blpc_pkg::CA_BT]) seq_r <= blpc_pkg::SEQ_LIN;
      else if (cfg_r[blpc_pkg::HYB_BIT]) seq_r <= blpc_pkg::SEQ_WRAP;
      else seq_r <= blpc_pkg::SEQ_HYB;
      wrapDone_r <= 1'b0;
      seqStop_r <= 1'b0;
      hiSel_r <= 1'b1;
    end else if ((state_r == blpc_pkg::ST_DATA) && edgeS) begin
      hiSel_r <= ~hiSel_r;
      if (hiSel_r) begin
        hiByte_r <= dqS;
        maskHi_r <= rwdsS;
      end
      if (wordAdv) begin
        addr_r <= nextAddr;
        wrapDone_r <= wrapDoneNxt;
        seqStop_r <= seqStopNxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Word hand-off into the FIFO
  // ----------------------------------------------------------------
  // Lost words are flagged; the link itself cannot be held off
  logic overrun_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pushValid_r <= 1'b0;
      pushData_r <= '0;
      overrun_r <= 1'b0;
    end else begin
      if (wordAdv && !isReg_r) begin
        pushValid_r <= 1'b1;
        pushData_r <= {!isRead_r, maskHi_r, rwdsS, addr_r, hiByte_r, dqS};
      end else if (fifoInReady) begin
        pushValid_r <= 1'b0;
      end
      if (wordDone && pushValid_r && !fifoInReady && !seqStop_r) overrun_r <= 1'b1;
      else if (hwRst) overrun_r <= 1'b0;
    end
  end

  blpc_fifo #(.W(FW), .D(FD)) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inValid(pushValid_r),
    .inReady(fifoInReady),
    .inData(pushData_r),
    .outValid(memValid),
    .outReady(memReady),
    .outData(fifoOut)
  );
  assign memWe = fifoOut[FW-1];
  assign memMask = fifoOut[FW-2 -: 2];
  assign memAddr = fifoOut[16 +: AW];
  assign memWdata = fifoOut[15:0];

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [7:0] dqOut_r;
  logic dqOe_r, rwdsOut_r, rwdsOe_r;
  logic [15:0] rdWord;
  // Array read data is whatever the user side holds at that moment
  assign rdWord = isReg_r ? cfg_r : memRdata;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dqOut_r <= 8'h00;
      dqOe_r <= 1'b0;
      rwdsOut_r <= 1'b0;
      rwdsOe_r <= 1'b0;
    end else if (hwRst || csS || (state_r == blpc_pkg::ST_ENTRY)
                 || (state_r == blpc_pkg::ST_PDOWN)) begin
      dqOe_r <= 1'b0;
      rwdsOe_r <= 1'b0;
      rwdsOut_r <= 1'b0;
    end else if (state_r == blpc_pkg::ST_IDLE) begin
      rwdsOe_r <= 1'b1;
      rwdsOut_r <= cfg_r[blpc_pkg::FIX_BIT] || refPend_r;
    end else if (caLast) begin
      rwdsOe_r <= caNext[blpc_pkg::CA_RW];
      rwdsOut_r <= 1'b0;
    end else if ((state_r == blpc_pkg::ST_DATA) && isRead_r && edgeS) begin
      dqOe_r <= 1'b1;
      dqOut_r <= hiSel_r ? rdWord[15:8] : rdWord[7:0];
      rwdsOut_r <= hiSel_r;
    end
  end
  assign dqOut = dqOut_r;
  assign dqOe = dqOe_r;
  assign rwdsOut = rwdsOut_r;
  assign rwdsOe = rwdsOe_r;

  // ----------------------------------------------------------------
  // Configuration word
  // ----------------------------------------------------------------
  logic [7:0] regHi_r;
  logic [2:0] drive_r;
  logic inPd_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= blpc_pkg::CFG_RST;
      regHi_r <= 8'h00;
    end else if (hwRst) begin
      cfg_r <= blpc_pkg::CFG_RST;
    end else if (wake) begin
      cfg_r[blpc_pkg::PD_BIT] <= 1'b1;
    end else if ((state_r == blpc_pkg::ST_REGW) && edgeS) begin
      // Strobe level is not consulted here
      if (byteCnt_r == 3'h0) regHi_r <= dqS;
      else if (byteCnt_r == 3'h1) cfg_r <= {regHi_r, dqS};
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_r <= 3'h0;
      inPd_r <= 1'b0;
    end else begin
      drive_r <= cfg_r[blpc_pkg::DRV_LO +: 3];
      inPd_r <= (state_r == blpc_pkg::ST_PDOWN);
    end
  end
  assign driveStrength = drive_r;
  assign inPowerDown = inPd_r;
  assign overrun = overrun_r;

  // ----------------------------------------------------------------
  // Self refresh and power-down timing
  // ----------------------------------------------------------------
  logic [RCW-1:0] refCnt_r;
  logic [4:0] busy_r;
  logic refOk;
  // Refresh may overlap register capture
  assign refOk = (state_r == blpc_pkg::ST_IDLE) || (state_r == blpc_pkg::ST_REGW);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      refCnt_r <= REF_LOAD;
      busy_r <= 5'h00;
      refPend_r <= 1'b0;
    end else if (hwRst || (state_r == blpc_pkg::ST_ENTRY) || (state_r == blpc_pkg::ST_PDOWN)) begin
      refCnt_r <= REF_LOAD;
      busy_r <= 5'h00;
      refPend_r <= 1'b0;
    end else begin
      refCnt_r <= (refCnt_r == '0) ? REF_LOAD : refCnt_r - RCW'(1);
      if (busy_r != 5'h00) busy_r <= busy_r - 5'h01;
      else if (refPend_r && refOk) busy_r <= BUSY_LOAD;
      if (refCnt_r == '0) refPend_r <= 1'b1;
      else if (busy_r == 5'h01) refPend_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pdCnt_r <= PD_LOAD;
      csLow_r <= 1'b0;
    end else begin
      if (state_r == blpc_pkg::ST_ENTRY) pdCnt_r <= pdCnt_r - PCW'(1);
      else pdCnt_r <= PD_LOAD;
      if (state_r != blpc_pkg::ST_PDOWN) csLow_r <= 1'b0;
      else if (!csS) csLow_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [5:0] latSeen_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) latSeen_r <= 6'h00;
    else if (state_r != blpc_pkg::ST_LAT) latSeen_r <= 6'h00;
    else if (edgeS) latSeen_r <= latSeen_r + 6'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_caStrobe;
    (state_r == blpc_pkg::ST_CA) && dbl_r && !csS |-> rwdsOe_r && rwdsOut_r;
  endproperty
  a_caStrobe: assert property (p_caStrobe) else $error("strobe not high in command phase");
  property p_latCount;
    latDone |-> (latSeen_r + 6'h01) == (dbl_r ? 6'h1C : 6'h0E) ||
                cfg_r[blpc_pkg::LAT_LO +: 4] != blpc_pkg::LAT_C7;
  endproperty
  a_latCount: assert property (p_latCount) else $error("latency edge count wrong");
  property p_lat3;
    latDone && (cfg_r[blpc_pkg::LAT_LO +: 4] == blpc_pkg::LAT_C3) |-> latSeen_r == (dbl_r ? 6'h0B : 6'h05);
  endproperty
  a_lat3: assert property (p_lat3) else $error("three clock latency wrong");
  property p_hwReset;
    hwRst |=> (cfg_r == blpc_pkg::CFG_RST) ##1 (driveStrength == 3'h0);
  endproperty
  a_hwReset: assert property (p_hwReset) else $error("reset values wrong");
  property p_wrapGroup;
    pushValid_r && (seq_r == blpc_pkg::SEQ_WRAP) |->
      ((pushData_r[16 +: AW] & ~mask) == (start_r & ~mask));
  endproperty
  a_wrapGroup: assert property (p_wrapGroup) else $error("wrap left its group");
  property p_linear;
    wordAdv && (seq_r == blpc_pkg::SEQ_LIN) |=> addr_r == $past(addr_r) + AW'(1);
  endproperty
  a_linear: assert property (p_linear) else $error("linear step wrong");
  property p_hybrid;
    wordAdv && (seq_r == blpc_pkg::SEQ_HYB) && !wrapDone_r && (wrapN == start_r) |=>
      wrapDone_r && (addr_r == ((start_r & ~mask) + mask + AW'(1)));
  endproperty
  a_hybrid: assert property (p_hybrid) else $error("hybrid jump wrong");
  property p_pdQuiet;
    (state_r == blpc_pkg::ST_PDOWN) && !wake && !hwRst |=>
      (state_r == blpc_pkg::ST_PDOWN) && !dqOe && !rwdsOe && !refPend_r;
  endproperty
  a_pdQuiet: assert property (p_pdQuiet) else $error("power-down not quiet");
  property p_wakeBit;
    wake && !hwRst |=> (state_r == blpc_pkg::ST_IDLE) && cfg_r[blpc_pkg::PD_BIT];
  endproperty
  a_wakeBit: assert property (p_wakeBit) else $error("wake did not restore bit");
  property p_regCapture;
    (state_r == blpc_pkg::ST_REGW) && edgeS && (byteCnt_r == 3'h1) && !hwRst |=>
      cfg_r[7:0] == $past(dqS);
  endproperty
  a_regCapture: assert property (p_regCapture) else $error("register byte lost");

  c_hybridJump: cover property (wordAdv && (seq_r == blpc_pkg::SEQ_HYB) && !wrapDone_r
                                && (wrapN == start_r));
  c_doubleLat: cover property (latDone && dbl_r);
  c_regWrite: cover property ((state_r == blpc_pkg::ST_REGW) && (byteCnt_r == 3'h2));
  c_powerDown: cover property (wake);
endmodule : blpc_core

// *** blpc_fifo.sv ***
module blpc_fifo #(
  parameter int W = 35,
  parameter int D = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  // D must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_r, rdPtr_r;
  logic [AW:0] cnt_r;
  logic push, pop;
  assign inReady = (cnt_r != (AW+1)'(D));
  assign push = inValid && inReady;
  assign pop = (cnt_r != '0) && (!outValid || outReady);
  always_ff @(posedge sys_clk) begin
    if (push) mem[wrPtr_r] <= inData;
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + AW'(push);
      rdPtr_r <= rdPtr_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Registered output stage keeps the drain side glitch free
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (pop) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr_r];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end
endmodule : blpc_fifo

// *** blpc_host_model.sv ***
module blpc_host_model (
  output logic csN,
  output logic ck,
  output logic [7:0] dq,
  output logic bidir_data_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    csN = 1'b1;
    ck = 1'b0;
    dq = 8'h00;
    bidir_data_strobe = 1'b0;
  end
  // Data set up a quarter period before each edge
  task automatic put(input logic [7:0] b);
    dq = b;
    #31.25 ck = ~ck;
    #31.25;
  endtask : put
  // Host counts latency edges itself
  task automatic xfer(input logic [47:0] ca, input int lat, input int n, input logic [15:0] d);
    csN = 1'b0;
    #100;
    for (int i = 0; i < 6; i++) put(ca[47-8*i -: 8]);
    for (int i = 0; i < lat; i++) put(8'h00);
    for (int i = 0; i < n; i++) begin
      put(d[15:8]);
      put(d[7:0]);
      d = d + 16'h0001;
    end
    #100 csN = 1'b1;
    dq = ~dq;
    #400;
  endtask : xfer
endmodule : blpc_host_model

// *** blpc_pkg.sv ***
package blpc_pkg;
  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int ADDR_W = 16;
  // ----------------------------------------------------------------
  // Configuration word layout and reset value
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RST = 16'h8F2F;
  localparam int PD_BIT = 15;
  localparam int DRV_LO = 12;
  localparam int LAT_LO = 4;
  localparam int FIX_BIT = 3;
  localparam int HYB_BIT = 2;
  localparam int BL_LO = 0;
  // ----------------------------------------------------------------
  // Command-address phase layout
  // ----------------------------------------------------------------
  localparam int CA_BYTES = 6;
  localparam int CA_RW = 47;
  localparam int CA_AS = 46;
  localparam int CA_BT = 45;
  localparam int CA_ALO = 16;
  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] LAT_C3 = 4'hE;
  localparam logic [3:0] LAT_C4 = 4'hF;
  localparam logic [3:0] LAT_C5 = 4'h0;
  localparam logic [3:0] LAT_C6 = 4'h1;
  localparam logic [3:0] LAT_C7 = 4'h2;
  localparam logic [1:0] BL_128 = 2'h0;
  localparam logic [1:0] BL_64 = 2'h1;
  localparam logic [1:0] BL_16 = 2'h2;
  localparam logic [1:0] BL_32 = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PD_ENTRY_NS = 3000;
  localparam int PD_ENTRY_CYC = PD_ENTRY_NS * CLK_MHZ / 1000;
  localparam int REFRESH_NS = 4000;
  localparam int REFRESH_CYC = REFRESH_NS * CLK_MHZ / 1000;
  localparam int REFRESH_BUSY_CYC = 16;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CA = 3'h1, ST_LAT = 3'h3, ST_DATA = 3'h2,
    ST_REGW = 3'h6, ST_ENTRY = 3'h7, ST_PDOWN = 3'h5
  } blpc_state_type;
  typedef enum logic [1:0] {SEQ_LIN = 2'h0, SEQ_WRAP = 2'h1, SEQ_HYB = 2'h3} blpc_seq_type;
endpackage : blpc_pkg

// *** tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, resetN = 1'b1, memReady = 1'b0, sawHigh = 1'b0;
  logic csN, ck, rwdsIn, dqOe, rwdsOut, rwdsOe, memValid, memWe, inPowerDown, overrun;
  logic [7:0] dqIn, dqOut, rdHi;
  logic [1:0] memMask;
  logic [15:0] memAddr, memWdata;
  logic [2:0] driveStrength;
  logic [15:0] qa[$], qd[$];
  logic [2:0] qw[$];
  int n_fail = 0, samples_checked = 0;
  initial forever #4 sys_clk = ~sys_clk;
  blpc_host_model host (.csN(csN), .ck(ck), .dq(dqIn), .bidir_data_strobe(rwdsIn));
  blpc_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .csN(csN), .ck(ck), .resetN(resetN),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .rwdsIn(rwdsIn), .rwdsOut(rwdsOut),
    .rwdsOe(rwdsOe), .memValid(memValid), .memReady(memReady), .memWe(memWe),
    .memMask(memMask), .memAddr(memAddr), .memWdata(memWdata), .memRdata(16'h0000),
    .driveStrength(driveStrength), .inPowerDown(inPowerDown), .overrun(overrun));
  always @(posedge sys_clk) begin
    if (memValid && memReady) qa.push_back(memAddr);
    if (memValid && memReady) qd.push_back(memWdata);
    if (memValid && memReady) qw.push_back({memWe, memMask});
    if (dqOe && rwdsOut) rdHi <= dqOut;
    if (!csN && rwdsOe && rwdsOut) sawHigh <= 1'b1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic regw(input logic [15:0] v);
    host.xfer({2'b01, 46'h0}, 0, 1, v);
  endtask : regw
  // Mode 0 linear, 1 legacy wrap, 2 hybrid; g is the group in words
  task automatic burst(input logic [15:0] a, input int g, input int m, input int lat, input int n);
    logic [15:0] e;
    qa.delete();
    qd.delete();
    qw.delete();
    sawHigh = 1'b0;
    host.xfer({2'b00, m == 0, 16'h0000, a[15:3], 13'h0000, a[2:0]}, lat, n, 16'h1234);
    @(posedge sys_clk) memReady <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(16'(qa.size()), 16'((m == 1) ? g : n));
    chk(qd[0], 16'h1234);
    chk(16'(sawHigh), 16'h0001);
    for (int i = 0; i < qa.size(); i++) begin
      e = (a & ~16'(g - 1)) | ((a + 16'(i)) & 16'(g - 1));
      if (m == 0 || (m == 2 && i >= g)) e = (m == 0) ? a + 16'(i) : (a & ~16'(g - 1)) + 16'(i);
      chk(qa[i], e);
      chk(16'(qw[i]), 16'h0004);
    end
    $display("burst mode %0d at %h done", m, a);
  endtask : burst
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(16'(driveStrength), 16'h0000);
    burst(16'h0003, 16, 0, 28, 10);
    regw(16'hDFEA);
    chk(16'(driveStrength), 16'h0005);
    burst(16'h000C, 8, 2, 12, 12);
    regw(16'hDFFF);
    burst(16'h000A, 16, 1, 16, 18);
    host.xfer({2'b11, 46'h0}, 16, 1, 16'h0000);
    chk({rdHi, dqOut}, 16'hDFFF);
    $display("register read test done");
    regw(16'h5F0E);
    repeat (400) @(posedge sys_clk);
    chk(16'(inPowerDown), 16'h0001);
    host.xfer({2'b01, 46'h0}, 0, 1, 16'hDFEA);
    chk(16'(inPowerDown), 16'h0000);
    @(posedge sys_clk) memReady <= 1'b0;
    burst(16'h0002, 8, 1, 20, 8);
    chk(16'(overrun), 16'h0000);
    @(posedge sys_clk) memReady <= 1'b0;
    host.xfer({3'b001, 45'h0}, 20, 12, 16'h0000);
    chk(16'(overrun), 16'h0001);
    @(posedge sys_clk) resetN <= 1'b0;
    repeat (5) @(posedge sys_clk);
    resetN <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(16'(driveStrength), 16'h0000);
    chk(16'(overrun), 16'h0000);
    $display("power and reset test done");
    finish_test();
  end
endmodule : tb
